// File: rtl/sdsi_top.sv
// Status, receive data and read map of the bus controller, host side registers.
module sdsi_top
  import sdsi_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst,
  // Host register port, strobes active high after board inversion.
  input  wire logic       chip_sel,
  input  wire logic       host_read_strobe,
  input  wire logic       host_write_strobe,
  input  wire logic [2:0] host_addr,
  input  wire logic [7:0] host_wdata,
  output logic      [7:0] host_rdata,
  output logic            host_rdata_oe,
  // Transfer handshake.
  input  wire logic       xfer_ack_in,
  input  wire logic       transfer_end_in,
  output logic            xfer_req_out,
  output logic            host_irq,
  // Bus pins, low true as on the cable.
  input  wire logic [7:0] bus_data_n,
  input  wire logic       bus_parity_n,
  input  wire logic       bus_bsy_n,
  input  wire logic       bus_req_n,
  input  wire logic       bus_ack_n,
  input  wire logic       bus_atn_n,
  input  wire logic       bus_msg_n,
  input  wire logic       bus_cd_n,
  input  wire logic       bus_io_n,
  input  wire logic       bus_sel_n,
  input  wire logic       bus_rst_n,
  // Bus driver control and transmit side events.
  output logic            bus_drivers_en,
  output logic            xfer_inhibit,
  input  wire logic       send_byte_loaded,
  input  wire logic       send_byte_on_bus
);

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers. Live reads use synced copies, so they lag the pins by two cycles.

  logic [7:0] data_n_s;
  logic [10:0] ctl_s;
  logic par_n_s, bsy_n_s, req_n_s, ack_n_s, atn_n_s, msg_n_s, cd_n_s, io_n_s, sel_n_s, rst_n_s, end_s;

  sdsi_sync #(.WIDTH(8)) u_sync_data (
    .clk      (clk),
    .rst      (rst),
    .async_in (bus_data_n),
    .sync_out (data_n_s)
  );

  sdsi_sync #(.WIDTH(11)) u_sync_ctl (
    .clk      (clk),
    .rst      (rst),
    .async_in ({transfer_end_in, bus_parity_n, bus_bsy_n, bus_req_n, bus_ack_n, bus_atn_n,
                bus_msg_n, bus_cd_n, bus_io_n, bus_sel_n, bus_rst_n}),
    .sync_out (ctl_s)
  );

  assign {end_s, par_n_s, bsy_n_s, req_n_s, ack_n_s, atn_n_s, msg_n_s, cd_n_s, io_n_s, sel_n_s, rst_n_s} = ctl_s;

  ////////////////////////////////////////////////////////////////////////////////
  // Register state and host access decode.

  logic [7:0] mode_q;
  logic [7:0] init_q;
  logic [7:0] target_q;
  logic       done_q;
  logic       final_sent_q;
  logic       req_q;
  logic       par_err_q;
  logic       irq_q;
  logic       busy_lost_q;
  logic [7:0] rx_q;
  logic       req_n_d1_q;
  logic       ack_n_d1_q;
  logic [$clog2(BUS_SETTLE_CYCLES+1)-1:0] bsy_cnt_q;
  logic [$clog2(END_MIN_CYCLES+1)-1:0]    end_cnt_q;
  logic [7:0] status;
  logic       host_rd;
  logic       host_wr;
  logic       dma_rd;
  logic       clr_rd;
  logic       phase_agree;
  logic       busy_trip;
  logic       capture;
  logic       fifo_in_ready;
  logic       fifo_out_valid;
  logic [7:0] fifo_out_data;

  assign host_rd = chip_sel & host_read_strobe;
  assign host_wr = chip_sel & host_write_strobe;
  // chip select and acknowledge are exclusive, so the two read paths never collide.
  assign dma_rd  = xfer_ack_in & host_read_strobe & ~chip_sel;
  assign clr_rd  = host_rd & (host_addr == ADDR_CLEAR_ERRORS);

  ////////////////////////////////////////////////////////////////////////////////
  // Phase compare and busy watch.

  assign phase_agree  = ({~msg_n_s, ~cd_n_s, ~io_n_s} == target_q[TGT_MSG:TGT_IO]);
  assign xfer_inhibit = ~phase_agree;
  assign busy_trip    = mode_q[MODE_BUSY_WATCH] & (bsy_cnt_q == ($bits(bsy_cnt_q))'(BUS_SETTLE_CYCLES));
  assign bus_drivers_en = ~busy_lost_q & phase_agree;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      bsy_cnt_q <= '0;
    else if (!bsy_n_s || !mode_q[MODE_BUSY_WATCH])
      bsy_cnt_q <= '0;
    else if (bsy_cnt_q != ($bits(bsy_cnt_q))'(BUS_SETTLE_CYCLES))
      bsy_cnt_q <= bsy_cnt_q + 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control registers written by the host.

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mode_q   <= MODE_RESET;
      init_q   <= INIT_RESET;
      target_q <= TARGET_RESET;
    end
    else
    begin
      if (host_wr && host_addr == ADDR_OPERATING_MODE)
        mode_q <= host_wdata;
      if (host_wr && host_addr == ADDR_INITIATOR_CTRL)
        init_q <= host_wdata & INIT_RW_MASK;
      if (host_wr && host_addr == ADDR_TARGET_PHASE)
        target_q <= {1'b0, 3'h0, host_wdata[3:0]};
      if (busy_trip)
      begin
        mode_q[MODE_BLOCK_XFER] <= 1'b0;
        init_q                  <= init_q & ~INIT_BUSY_CLEAR_MASK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transfer-done, final-byte-sent and request flags.

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      end_cnt_q <= '0;
    else if (end_s && xfer_ack_in && (host_read_strobe || host_write_strobe))
    begin
      if (end_cnt_q != ($bits(end_cnt_q))'(END_MIN_CYCLES))
        end_cnt_q <= end_cnt_q + 1'b1;
    end
    else
      end_cnt_q <= '0;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      done_q       <= 1'b0;
      final_sent_q <= 1'b0;
      req_q        <= 1'b0;
    end
    else if (!mode_q[MODE_BLOCK_XFER])
    begin
      done_q       <= 1'b0;
      final_sent_q <= 1'b0;
      req_q        <= 1'b0;
    end
    else
    begin
      if (end_cnt_q == ($bits(end_cnt_q))'(END_MIN_CYCLES))
        done_q <= 1'b1;
      if (done_q && send_byte_on_bus)
        final_sent_q <= 1'b1;
      if (xfer_ack_in && (mode_q[MODE_TARGET] ? host_write_strobe : host_read_strobe))
        req_q <= 1'b0;
      else if (send_byte_loaded || fifo_out_valid)
        req_q <= 1'b1;
    end
  end

  assign xfer_req_out = req_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Receive capture through the FIFO into the received byte latch.

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      req_n_d1_q <= 1'b1;
      ack_n_d1_q <= 1'b1;
    end
    else
    begin
      req_n_d1_q <= req_n_s;
      ack_n_d1_q <= ack_n_s;
    end
  end

  // Capture on the falling edge of the low-true strobe, only while phases agree.
  assign capture = mode_q[MODE_BLOCK_XFER] & phase_agree &
                   (mode_q[MODE_TARGET] ? (ack_n_d1_q & ~ack_n_s) : (req_n_d1_q & ~req_n_s));

  // A full FIFO drops further bytes; the host drains it via the request handshake or by reading the received byte register.
  sdsi_fifo #(.WIDTH(RX_WIDTH), .DEPTH(RX_DEPTH)) u_rx_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (capture),
    .in_ready  (fifo_in_ready),
    .in_data   (~data_n_s),
    .out_valid (fifo_out_valid),
    .out_ready (dma_rd | (host_rd && host_addr == ADDR_RECEIVED_BYTE)),
    .out_data  (fifo_out_data)
  );

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rx_q <= DATA_RESET;
    else if (fifo_out_valid && (dma_rd || (host_rd && host_addr == ADDR_RECEIVED_BYTE)))
      rx_q <= fifo_out_data;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Error latches and interrupt.

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      par_err_q   <= 1'b0;
      busy_lost_q <= 1'b0;
      irq_q       <= 1'b0;
    end
    else
    begin
      if (mode_q[MODE_PARITY_CHECK] && capture && odd_parity_bad(~data_n_s, ~par_n_s))
        par_err_q <= 1'b1;
      else if (clr_rd)
        par_err_q <= 1'b0;
      if (busy_trip)
        busy_lost_q <= 1'b1;
      else if (clr_rd)
        busy_lost_q <= 1'b0;
      if (busy_trip ||
          (mode_q[MODE_PARITY_INT_ON] && mode_q[MODE_PARITY_CHECK] && capture &&
           odd_parity_bad(~data_n_s, ~par_n_s)) ||
          (mode_q[MODE_DONE_INT_ON] && !done_q && end_cnt_q == ($bits(end_cnt_q))'(END_MIN_CYCLES)))
        irq_q <= 1'b1;
      else if (clr_rd)
        irq_q <= 1'b0;
    end
  end

  assign host_irq = irq_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Read mux.

  always_comb
  begin
    status = {done_q, req_q, par_err_q, irq_q, phase_agree, busy_lost_q, ~atn_n_s, ~ack_n_s};
    host_rdata    = 8'h00;
    host_rdata_oe = host_rd | dma_rd;
    if (dma_rd)
      host_rdata = rx_q;
    else
      unique case (host_addr)
        ADDR_LIVE_BUS_DATA:    host_rdata = ~data_n_s;
        ADDR_INITIATOR_CTRL:   host_rdata = init_q;
        ADDR_OPERATING_MODE:   host_rdata = mode_q;
        ADDR_TARGET_PHASE:     host_rdata = {final_sent_q, target_q[6:0]};
        ADDR_LIVE_BUS_CONTROL: host_rdata = {~rst_n_s, ~bsy_n_s, ~req_n_s, ~msg_n_s, ~cd_n_s, ~io_n_s, ~sel_n_s, ~par_n_s};
        ADDR_TRANSFER_STATUS:  host_rdata = status;
        ADDR_RECEIVED_BYTE:    host_rdata = rx_q;
        ADDR_CLEAR_ERRORS:     host_rdata = 8'h00;
      endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.

  sequence block_off_s;
    !mode_q[MODE_BLOCK_XFER];
  endsequence

  done_clear_a: assert property (@(posedge clk) disable iff (rst) block_off_s |=> !done_q)
    else $error("Transfer-done set with block mode off.");
  final_clear_a: assert property (@(posedge clk) disable iff (rst) block_off_s |=> !final_sent_q)
    else $error("Final-byte flag set with block mode off.");
  req_drop_a: assert property (@(posedge clk) disable iff (rst) block_off_s |=> !xfer_req_out)
    else $error("Request held with block mode off.");
  req_mirror_a: assert property (@(posedge clk) disable iff (rst) status[STAT_XFER_REQ] == xfer_req_out)
    else $error("Status request bit differs from pin.");
  irq_mirror_a: assert property (@(posedge clk) disable iff (rst) status[STAT_IRQ] == host_irq)
    else $error("Status interrupt bit differs from pin.");
  busy_off_a: assert property (@(posedge clk) disable iff (rst) busy_trip |=> !mode_q[MODE_BLOCK_XFER] && !bus_drivers_en && (init_q[5:0] == 6'h00))
    else $error("Busy lost did not clear controls.");
  busy_gate_a: assert property (@(posedge clk) disable iff (rst) $rose(busy_lost_q) |-> $past(mode_q[MODE_BUSY_WATCH]))
    else $error("Busy lost set while watch disabled.");
  parity_gate_a: assert property (@(posedge clk) disable iff (rst) $rose(par_err_q) |-> $past(mode_q[MODE_PARITY_CHECK]))
    else $error("Parity error set while check disabled.");
  clear_read_a: assert property (@(posedge clk) disable iff (rst) clr_rd && !busy_trip && !capture && !(end_cnt_q != 0) |=> !busy_lost_q && !par_err_q)
    else $error("Clear read left error latches set.");
  phase_inhibit_a: assert property (@(posedge clk) disable iff (rst) !phase_agree |-> !capture && xfer_inhibit)
    else $error("Transfer allowed during phase mismatch.");

  // A valid end held the minimum time must show as transfer-done one edge later.
  sequence end_valid_s;
    mode_q[MODE_BLOCK_XFER] && (end_cnt_q == ($bits(end_cnt_q))'(END_MIN_CYCLES));
  endsequence

  sequence ack_match_s;
    mode_q[MODE_BLOCK_XFER] && xfer_ack_in && (mode_q[MODE_TARGET] ? host_write_strobe : host_read_strobe);
  endsequence

  done_set_a: assert property (@(posedge clk) disable iff (rst) end_valid_s |=> done_q)
    else $error("Valid end did not set transfer-done.");
  req_ack_drop_a: assert property (@(posedge clk) disable iff (rst) ack_match_s |=> !xfer_req_out)
    else $error("Request held after acknowledge with strobe.");
  rx_capture_a: assert property (@(posedge clk) disable iff (rst) capture && fifo_in_ready |=> fifo_out_valid)
    else $error("Captured byte did not reach the buffer.");

endmodule // sdsi_top

// File: inc/sdsi_pkg.sv
// Package with register map, field positions, reset values and timing for the bus status block.
package sdsi_pkg;

  // Register addresses on the three-bit host address.
  localparam logic [2:0] ADDR_LIVE_BUS_DATA    = 3'h0;
  localparam logic [2:0] ADDR_INITIATOR_CTRL   = 3'h1;
  localparam logic [2:0] ADDR_OPERATING_MODE   = 3'h2;
  localparam logic [2:0] ADDR_TARGET_PHASE     = 3'h3;
  localparam logic [2:0] ADDR_LIVE_BUS_CONTROL = 3'h4;
  localparam logic [2:0] ADDR_TRANSFER_STATUS  = 3'h5;
  localparam logic [2:0] ADDR_RECEIVED_BYTE    = 3'h6;
  localparam logic [2:0] ADDR_CLEAR_ERRORS     = 3'h7;

  // Operating mode field positions.
  localparam int MODE_BURST         = 7;
  localparam int MODE_TARGET        = 6;
  localparam int MODE_PARITY_CHECK  = 5;
  localparam int MODE_PARITY_INT_ON = 4;
  localparam int MODE_DONE_INT_ON   = 3;
  localparam int MODE_BUSY_WATCH    = 2;
  localparam int MODE_BLOCK_XFER    = 1;
  localparam int MODE_ARB_REQUEST   = 0;

  // Transfer status field positions.
  localparam int STAT_XFER_DONE   = 7;
  localparam int STAT_XFER_REQ    = 6;
  localparam int STAT_PARITY_ERR  = 5;
  localparam int STAT_IRQ         = 4;
  localparam int STAT_PHASE_AGREE = 3;
  localparam int STAT_BUSY_LOST   = 2;
  localparam int STAT_ATN         = 1;
  localparam int STAT_ACK         = 0;

  // Target phase control field positions.
  localparam int TGT_FINAL_SENT = 7;
  localparam int TGT_REQ        = 3;
  localparam int TGT_MSG        = 2;
  localparam int TGT_CD         = 1;
  localparam int TGT_IO         = 0;

  // Initiator control: bits cleared on busy lost, and the drive-busy bit.
  localparam logic [7:0] INIT_BUSY_CLEAR_MASK = 8'h3f;
  localparam int         INIT_DRIVE_BUSY      = 3;
  localparam logic [7:0] INIT_RW_MASK         = 8'h9f;

  // Reset values.
  localparam logic [7:0] MODE_RESET   = 8'h00;
  localparam logic [7:0] INIT_RESET   = 8'h00;
  localparam logic [7:0] TARGET_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET   = 8'h00;

  // Timing at 200 MHz.
  localparam int CLK_PERIOD_PS     = 5000;
  localparam int BUS_SETTLE_NS     = 400;
  localparam int BUS_SETTLE_CYCLES = (BUS_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int END_MIN_NS        = 10;
  localparam int END_MIN_CYCLES    = (END_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Receive buffer shape.
  localparam int RX_WIDTH = 8;
  localparam int RX_DEPTH = 4;

  // Odd parity check over a byte with its parity line, both active high.
  function automatic logic odd_parity_bad(input logic [7:0] data, input logic par);
    odd_parity_bad = ~(^{data, par});
  endfunction

endpackage

// File: rtl/sdsi_sync.sv
// Two-flop synchroniser bank for asynchronous bus pins.
module sdsi_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             rst,
  // Data.
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q   <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule // sdsi_sync

// File: rtl/sdsi_fifo.sv
// Small flip-flop FIFO with valid and ready on both sides.
module sdsi_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             rst,
  // Fill side.
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side.
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  assign in_ready  = (count_q != (AW+1)'(DEPTH));
  assign out_valid = (count_q != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_q[rd_q];

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_q    <= '0;
      rd_q    <= '0;
      count_q <= '0;
      for (int i = 0; i < DEPTH; i++)
        mem_q[i] <= '0;
    end
    else
    begin
      if (push)
      begin
        mem_q[wr_q] <= in_data;
        wr_q        <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop)
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      if (push && !pop)
        count_q <= count_q + 1'b1;
      else if (pop && !push)
        count_q <= count_q - 1'b1;
    end
  end

endmodule // sdsi_fifo

// File: testbench/sdsi_host.sv
// Host processor and transfer controller model on the register port.
module sdsi_host (
  // Clock.
  input  wire logic       clk,
  // Register port.
  output logic            chip_sel,
  output logic            host_read_strobe,
  output logic            host_write_strobe,
  output logic [2:0]      host_addr,
  output logic [7:0]      host_wdata,
  input  wire logic [7:0] host_rdata,
  // Transfer handshake.
  output logic            xfer_ack_in,
  output logic            transfer_end_in
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    chip_sel = 1'b0;
    host_read_strobe = 1'b0;
    host_write_strobe = 1'b0;
    host_addr = 3'h0;
    host_wdata = 8'h00;
    xfer_ack_in = 1'b0;
    transfer_end_in = 1'b0;
  end

  task automatic reg_wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    #1;
    chip_sel = 1'b1;
    host_write_strobe = 1'b1;
    host_addr = a;
    host_wdata = v;
    @(posedge clk);
    #1;
    chip_sel = 1'b0;
    host_write_strobe = 1'b0;
    host_wdata = ~v;
  endtask

  task automatic reg_rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    #1;
    chip_sel = 1'b1;
    host_read_strobe = 1'b1;
    host_addr = a;
    @(posedge clk);
    v = host_rdata;
    #1;
    chip_sel = 1'b0;
    host_read_strobe = 1'b0;
  endtask

  // One send-side transfer write; chip select stays low.
  task automatic dma_wr();
    @(posedge clk);
    #1;
    xfer_ack_in = 1'b1;
    host_write_strobe = 1'b1;
    @(posedge clk);
    #1;
    xfer_ack_in = 1'b0;
    host_write_strobe = 1'b0;
  endtask

  // Chip select stays low for the whole transfer read.
  task automatic dma_rd(input int n, input logic eop, output logic [7:0] v);
    @(posedge clk);
    #1;
    xfer_ack_in = 1'b1;
    host_read_strobe = 1'b1;
    transfer_end_in = eop;
    repeat (n) @(posedge clk);
    v = host_rdata;
    #1;
    xfer_ack_in = 1'b0;
    host_read_strobe = 1'b0;
    transfer_end_in = 1'b0;
  endtask
endmodule // sdsi_host

// File: testbench/tb_top.sv
// Self-checking bench for the status and receive block.
module tb_top
  import sdsi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk, rst, chip_sel, host_read_strobe, host_write_strobe, xfer_ack_in, transfer_end_in;
  logic       host_rdata_oe, xfer_req_out, host_irq, bus_drivers_en, xfer_inhibit, send_byte_on_bus;
  logic       send_byte_loaded;
  logic       bus_parity_n, bus_bsy_n, bus_req_n, bus_ack_n, bus_atn_n, bus_msg_n, bus_cd_n, bus_io_n;
  logic [2:0] host_addr;
  logic [7:0] host_wdata, host_rdata, bus_data_n, d, r;
  int         n_fail, comparisons, lat;
  int         q[$];

  sdsi_top i_sdsi_top (
    .clk, .rst, .chip_sel, .host_read_strobe, .host_write_strobe, .host_addr, .host_wdata, .host_rdata,
    .host_rdata_oe, .xfer_ack_in, .transfer_end_in, .xfer_req_out, .host_irq, .bus_data_n, .bus_parity_n,
    .bus_bsy_n, .bus_req_n, .bus_ack_n, .bus_atn_n, .bus_msg_n, .bus_cd_n, .bus_io_n, .bus_sel_n(1'b1),
    .bus_rst_n(1'b1), .bus_drivers_en, .xfer_inhibit, .send_byte_loaded, .send_byte_on_bus
  );

  sdsi_host i_sdsi_host (
    .clk, .chip_sel, .host_read_strobe, .host_write_strobe, .host_addr, .host_wdata, .host_rdata,
    .xfer_ack_in, .transfer_end_in
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    i_sdsi_host.reg_wr(a, v);
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    i_sdsi_host.reg_rd(a, d);
    chk8(d, e);
  endtask

  task automatic st();
    i_sdsi_host.reg_rd(ADDR_TRANSFER_STATUS, d);
  endtask

  // A request that never comes must not hang the run.
  task automatic wait_req();
    int k;
    for (k = 0; k < 20 && xfer_req_out !== 1'b1; k++)
      tick(1);
    if (k == 20)
    begin
      n_fail++;
      stop_test();
    end
  endtask

  // The model keeps only what fits; a full buffer drops the newest byte.
  task automatic rx_byte(input logic [7:0] b, input logic bad);
    bus_data_n = ~b;
    bus_parity_n = bad ? ~(^b) : ^b;
    tick(3);
    bus_req_n = 1'b0;
    tick(5);
    bus_req_n = 1'b1;
    tick(4);
    if (q.size() < RX_DEPTH)
      q.push_back(b);
  endtask

  task automatic drain();
    while (q.size() > 0)
    begin
      wait_req();
      i_sdsi_host.dma_rd(1, 1'b0, d);
      chk8(d, lat[7:0]);
      lat = q.pop_front();
    end
    tick(3);
    chk1(xfer_req_out, 1'b0);
    rd(ADDR_RECEIVED_BYTE, lat[7:0]);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial
  begin
    rst = 1'b1;
    {bus_parity_n, bus_req_n, bus_ack_n, bus_atn_n, bus_msg_n, bus_cd_n, bus_io_n} = 7'h7f;
    bus_bsy_n = 1'b0;
    bus_data_n = 8'hff;
    send_byte_on_bus = 1'b0;
    send_byte_loaded = 1'b0;
    n_fail = 0;
    comparisons = 0;
    lat = DATA_RESET;
    void'($urandom(32'h62af));
    tick(2);
    rst = 1'b0;
    rd(ADDR_OPERATING_MODE, MODE_RESET);
    rd(ADDR_INITIATOR_CTRL, INIT_RESET);
    r = 8'($urandom) & 8'hf8;
    wr(ADDR_OPERATING_MODE, r);
    rd(ADDR_OPERATING_MODE, r);
    wr(ADDR_OPERATING_MODE, MODE_RESET);
    $display("test registers done");
    r = 8'($urandom);
    bus_data_n = r;
    {bus_ack_n, bus_atn_n} = r[1:0];
    tick(4);
    rd(ADDR_LIVE_BUS_DATA, ~r);
    rd(ADDR_TRANSFER_STATUS, {6'h02, ~r[0], ~r[1]});
    {bus_ack_n, bus_atn_n} = 2'b11;
    for (int p = 0; p < 16; p++)
    begin
      wr(ADDR_TARGET_PHASE, {5'h00, p[2:0]});
      {bus_msg_n, bus_cd_n, bus_io_n} = ~(p[2:0] ^ {2'b00, p[3]});
      tick(4);
      st();
      chk1(d[STAT_PHASE_AGREE], ~p[3]);
      chk1(xfer_inhibit, p[3]);
      chk1(bus_drivers_en, ~p[3]);
    end
    wr(ADDR_TARGET_PHASE, TARGET_RESET);
    {bus_msg_n, bus_cd_n, bus_io_n} = 3'h7;
    $display("test live lines done");
    wr(ADDR_OPERATING_MODE, 8'h32);
    repeat (RX_DEPTH + 1) rx_byte(8'($urandom), 1'b0);
    chk1(xfer_req_out, 1'b1);
    st();
    chk8(d & 8'h70, 8'h40);
    drain();
    rx_byte(8'($urandom), 1'b1);
    st();
    chk8(d & 8'h34, 8'h30);
    chk1(host_irq, 1'b1);
    st();
    chk1(d[STAT_PARITY_ERR], 1'b1);
    i_sdsi_host.reg_rd(ADDR_CLEAR_ERRORS, d);
    st();
    chk8(d & 8'h34, 8'h00);
    wr(ADDR_OPERATING_MODE, 8'h02);
    rx_byte(8'($urandom), 1'b1);
    st();
    chk1(d[STAT_PARITY_ERR], 1'b0);
    drain();
    $display("test receive done");
    wr(ADDR_OPERATING_MODE, 8'h0a);
    i_sdsi_host.dma_rd(6, 1'b1, d);
    st();
    chk8(d & 8'hd0, 8'h90);
    send_byte_on_bus = 1'b1;
    tick(1);
    send_byte_on_bus = 1'b0;
    tick(3);
    i_sdsi_host.reg_rd(ADDR_TARGET_PHASE, d);
    chk1(d[TGT_FINAL_SENT], 1'b1);
    wr(ADDR_OPERATING_MODE, 8'h42);
    send_byte_loaded = 1'b1;
    tick(1);
    send_byte_loaded = 1'b0;
    tick(1);
    chk1(xfer_req_out, 1'b1);
    i_sdsi_host.dma_wr();
    chk1(xfer_req_out, 1'b0);
    r = 8'($urandom);
    bus_data_n = ~r;
    bus_parity_n = ^r;
    tick(3);
    bus_ack_n = 1'b0;
    tick(5);
    bus_ack_n = 1'b1;
    tick(4);
    chk1(xfer_req_out, 1'b1);
    chk1(host_rdata_oe, 1'b0);
    rd(ADDR_RECEIVED_BYTE, lat[7:0]);
    rd(ADDR_RECEIVED_BYTE, r);
    lat = r;
    wr(ADDR_OPERATING_MODE, MODE_RESET);
    st();
    chk8(d & 8'hc0, 8'h00);
    rd(ADDR_TARGET_PHASE, TARGET_RESET);
    i_sdsi_host.reg_rd(ADDR_CLEAR_ERRORS, d);
    $display("test transfer end done");
    wr(ADDR_INITIATOR_CTRL, 8'h1f);
    wr(ADDR_OPERATING_MODE, 8'h06);
    bus_bsy_n = 1'b1;
    tick(70);
    st();
    chk1(d[STAT_BUSY_LOST], 1'b0);
    tick(20);
    st();
    chk8(d & 8'h14, 8'h14);
    chk1(bus_drivers_en, 1'b0);
    rd(ADDR_OPERATING_MODE, 8'h04);
    rd(ADDR_INITIATOR_CTRL, 8'h00);
    bus_bsy_n = 1'b0;
    wr(ADDR_OPERATING_MODE, MODE_RESET);
    i_sdsi_host.reg_rd(ADDR_CLEAR_ERRORS, d);
    st();
    chk8(d & 8'h34, 8'h00);
    chk1(host_irq, 1'b0);
    $display("test busy lost done");
    stop_test();
  end
endmodule // tb_top
